// file: include/pulse_pattern_pkg.sv
`default_nettype none
package pulse_pattern_pkg;
   // bus geometry: byte address is four times the register index
   localparam int          ADDR_W      = 18;
   localparam int          IDX_W       = 16;
   // register indices
   localparam logic [15:0] IDX_TRIG    = 16'hFF46;
   localparam logic [15:0] IDX_POL     = 16'hFF47;
   localparam logic [15:0] IDX_EN_HI   = 16'hFF48;
   localparam logic [15:0] IDX_EN_LO   = 16'hFF49;
   localparam logic [15:0] IDX_OUT_HI  = 16'hFF4A;
   localparam logic [15:0] IDX_OUT_LO  = 16'hFF4B;
   localparam logic [15:0] IDX_NEXT_UP = 16'hFF4C;
   localparam logic [15:0] IDX_NEXT_LO = 16'hFF4D;
   localparam logic [15:0] IDX_NEXT_G2 = 16'hFF4E;
   localparam logic [15:0] IDX_NEXT_G0 = 16'hFF4F;
   // reset values
   localparam logic [7:0]  RST_TRIG    = 8'h00;
   localparam logic [3:0]  RST_POL     = 4'hF;
   localparam logic [15:0] RST_EN      = 16'h0000;
   localparam logic [15:0] RST_NEXT    = 16'h0000;
   localparam logic [3:0]  RST_VALUE   = 4'h0;
   // fixed read fill for unused next-data bits
   localparam logic [3:0]  FILL_NIB    = 4'hF;
   localparam logic [7:0]  FILL_BYTE   = 8'hFF;
   // field layout of the trigger register: group n at [2n+1:2n]
   localparam int          TRIG_W      = 2;
   localparam int          GROUP_W     = 4;
   localparam int          GROUPS      = 4;
   // bus answers
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_DECERR = 2'h3;
endpackage
`default_nettype wire

// file: logic/pattern_group.sv
`timescale 1ns/1ps
`default_nettype none
module pattern_group #(
   parameter int W = 4
) (
   // clock and reset
   input  wire logic         mclk,
   input  wire logic         reset,
   // software access
   input  wire logic         sw_write,
   input  wire logic [W-1:0] sw_data,
   // group setup
   input  wire logic [W-1:0] pin_enable,
   input  wire logic [1:0]   trig_sel,
   input  wire logic         direct,
   input  wire logic [W-1:0] next_bits,
   // timer compare matches
   input  wire logic [3:0]   cmp_match,
   // state and pins
   output logic      [W-1:0] value_reg,
   output logic      [W-1:0] pin_reg
);
   logic [W-1:0] value_next;
   logic [W-1:0] pin_next;
   logic         fire;

   if (W < 1) begin : g_bad_width
      $error("group width must be positive");
   end

   always_comb begin
      fire       = cmp_match[trig_sel];
      value_next = value_reg;
      if (sw_write) begin
         value_next = (value_reg & pin_enable) | (sw_data & ~pin_enable);
      end
      if (fire) begin
         value_next = (value_next & ~pin_enable) | (next_bits & pin_enable);
      end
      pin_next = pin_enable & (direct ? value_next : ~value_next);
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         value_reg <= pulse_pattern_pkg::RST_VALUE;
         pin_reg   <= '0;
      end else begin
         value_reg <= value_next;
         pin_reg   <= pin_next;
      end
   end

   property p_value_reset;
      @(posedge mclk) reset |=> value_reg == '0;
   endproperty
   a_value_reset: assert property (p_value_reset) else $error("value not cleared");

   property p_locked_bits;
      @(posedge mclk) disable iff (reset)
         !fire |=> ((value_reg ^ $past(value_reg)) & $past(pin_enable)) == '0;
   endproperty
   a_locked_bits: assert property (p_locked_bits) else $error("locked bit moved");

   property p_match_load;
      @(posedge mclk) disable iff (reset)
         fire |=> (value_reg & $past(pin_enable)) == ($past(next_bits) & $past(pin_enable));
   endproperty
   a_match_load: assert property (p_match_load) else $error("match load wrong");

   property p_polarity;
      @(posedge mclk) disable iff (reset)
         !reset |=> pin_reg == ($past(pin_enable) & ($past(direct) ? value_reg : ~value_reg));
   endproperty
   a_polarity: assert property (p_polarity) else $error("pin polarity wrong");
endmodule
`default_nettype wire

// file: logic/pulse_pattern_output_regs.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - a set enable bit hands its pin to the pattern logic, a clear bit keeps it off.
// - the 16-bit output value, read as a high and a low byte, resets to zero.
// - output value bits that are enabled ignore software writes, others stay writable.
// - with groups 3 and 2 on one trigger the upper next byte is whole and its alias reads ones.
// - with separate triggers the upper next byte holds group 3 high, low nibble reads ones.
// - with separate triggers the group 2 alias holds group 2 low, high nibble reads ones.
// - with groups 1 and 0 on one trigger the lower next byte is whole and its alias reads ones.
// - with separate triggers the lower next byte holds group 1 high, low nibble reads ones.
// - with separate triggers the group 0 alias holds group 0 low, high nibble reads ones.
// - each group's two-bit trigger field picks timer compare channel 0 to 3.
// - a set polarity bit drives pins directly, a clear one inverts them.
module pulse_pattern_output_regs (
   // clock and reset
   input  wire logic                                  mclk,
   input  wire logic                                  reset,
   // axi4-lite write address
   input  wire logic [pulse_pattern_pkg::ADDR_W-1:0]  awaddr,
   input  wire logic [2:0]                            awprot,
   input  wire logic                                  awvalid,
   output logic                                       awready,
   // axi4-lite write data
   input  wire logic [31:0]                           wdata,
   input  wire logic [3:0]                            wstrb,
   input  wire logic                                  wvalid,
   output logic                                       wready,
   // axi4-lite write response
   output logic [1:0]                                 bresp,
   output logic                                       bvalid,
   input  wire logic                                  bready,
   // axi4-lite read address
   input  wire logic [pulse_pattern_pkg::ADDR_W-1:0]  araddr,
   input  wire logic [2:0]                            arprot,
   input  wire logic                                  arvalid,
   output logic                                       arready,
   // axi4-lite read data
   output logic [31:0]                                rdata,
   output logic [1:0]                                 rresp,
   output logic                                       rvalid,
   input  wire logic                                  rready,
   // timer unit compare matches, one pulse per channel
   input  wire logic [3:0]                            timer_unit_match,
   // pattern pins
   output logic [15:0]                                pattern_pin,
   output logic [15:0]                                pattern_pin_oe
);
   localparam int IW = pulse_pattern_pkg::IDX_W;

   // index of a byte address
   function automatic logic [IW-1:0] word_idx(input logic [pulse_pattern_pkg::ADDR_W-1:0] a);
      word_idx = a[pulse_pattern_pkg::ADDR_W-1:2];
   endfunction

   // whether an index names a register
   function automatic logic is_mapped(input logic [IW-1:0] idx);
      is_mapped = (idx >= pulse_pattern_pkg::IDX_TRIG) && (idx <= pulse_pattern_pkg::IDX_NEXT_G0);
   endfunction

   // bus state
   logic            awready_reg, awready_next;
   logic            wready_reg, wready_next;
   logic            aw_hold_reg, aw_hold_next;
   logic            w_hold_reg, w_hold_next;
   logic [IW-1:0]   aw_idx_reg, aw_idx_next;
   logic [7:0]      w_byte_reg, w_byte_next;
   logic            w_lane_reg, w_lane_next;
   logic            bvalid_reg, bvalid_next;
   logic [1:0]      bresp_reg, bresp_next;
   logic            arready_reg, arready_next;
   logic            rvalid_reg, rvalid_next;
   logic [31:0]     rdata_reg, rdata_next;
   logic [1:0]      rresp_reg, rresp_next;
   // write strobe toward the registers
   logic            aw_take, w_take, ar_take, wr_fire, wr_lane;
   logic [IW-1:0]   wr_idx, rd_idx;
   logic [7:0]      wr_byte;
   // configuration state
   logic [7:0]      trig_reg, trig_next;
   logic [3:0]      pol_reg, pol_next;
   logic [15:0]     enable_reg, enable_next;
   logic [15:0]     next_reg, next_next;
   logic [15:0]     oe_reg;
   logic [3:0]      grp_wr;
   logic            same_up, same_lo;
   logic [15:0]     value_all;
   logic [15:0]     pin_all;
   logic [7:0]      rd_byte;

   // bus handshakes
   always_comb begin
      aw_take      = awvalid && awready_reg;
      w_take       = wvalid && wready_reg;
      ar_take      = arvalid && arready_reg;
      aw_idx_next  = aw_take ? word_idx(awaddr) : aw_idx_reg;
      w_byte_next  = w_take ? wdata[7:0] : w_byte_reg;
      w_lane_next  = w_take ? wstrb[0] : w_lane_reg;
      wr_fire      = (aw_hold_reg || aw_take) && (w_hold_reg || w_take) && !bvalid_reg;
      wr_idx       = aw_idx_next;
      wr_byte      = w_byte_next;
      wr_lane      = w_lane_next;
      aw_hold_next = (aw_hold_reg || aw_take) && !wr_fire;
      w_hold_next  = (w_hold_reg || w_take) && !wr_fire;
      bvalid_next  = wr_fire || (bvalid_reg && !bready);
      bresp_next   = bresp_reg;
      if (wr_fire) begin
         bresp_next = is_mapped(wr_idx) ? pulse_pattern_pkg::RESP_OKAY
                                        : pulse_pattern_pkg::RESP_DECERR;
      end
      awready_next = !aw_hold_next && !bvalid_next;
      wready_next  = !w_hold_next && !bvalid_next;
      rd_idx       = word_idx(araddr);
      rvalid_next  = ar_take || (rvalid_reg && !rready);
      arready_next = !rvalid_next;
      rdata_next   = rdata_reg;
      rresp_next   = rresp_reg;
      if (ar_take) begin
         rdata_next = {24'h000000, rd_byte};
         rresp_next = is_mapped(rd_idx) ? pulse_pattern_pkg::RESP_OKAY
                                        : pulse_pattern_pkg::RESP_DECERR;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         awready_reg <= 1'b0;
         wready_reg  <= 1'b0;
         aw_hold_reg <= 1'b0;
         w_hold_reg  <= 1'b0;
         aw_idx_reg  <= '0;
         w_byte_reg  <= 8'h00;
         w_lane_reg  <= 1'b0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= pulse_pattern_pkg::RESP_OKAY;
         arready_reg <= 1'b0;
         rvalid_reg  <= 1'b0;
         rdata_reg   <= 32'h00000000;
         rresp_reg   <= pulse_pattern_pkg::RESP_OKAY;
      end else begin
         awready_reg <= awready_next;
         wready_reg  <= wready_next;
         aw_hold_reg <= aw_hold_next;
         w_hold_reg  <= w_hold_next;
         aw_idx_reg  <= aw_idx_next;
         w_byte_reg  <= w_byte_next;
         w_lane_reg  <= w_lane_next;
         bvalid_reg  <= bvalid_next;
         bresp_reg   <= bresp_next;
         arready_reg <= arready_next;
         rvalid_reg  <= rvalid_next;
         rdata_reg   <= rdata_next;
         rresp_reg   <= rresp_next;
      end
   end

   assign awready = awready_reg;
   assign wready  = wready_reg;
   assign bvalid  = bvalid_reg;
   assign bresp   = bresp_reg;
   assign arready = arready_reg;
   assign rvalid  = rvalid_reg;
   assign rdata   = rdata_reg;
   assign rresp   = rresp_reg;

   // groups sharing a trigger
   assign same_up = trig_reg[7:6] == trig_reg[5:4];
   assign same_lo = trig_reg[3:2] == trig_reg[1:0];

   // read data
   always_comb begin
      case (rd_idx)
         pulse_pattern_pkg::IDX_TRIG:    rd_byte = trig_reg;
         pulse_pattern_pkg::IDX_POL:     rd_byte = {4'h0, pol_reg};
         pulse_pattern_pkg::IDX_EN_HI:   rd_byte = enable_reg[15:8];
         pulse_pattern_pkg::IDX_EN_LO:   rd_byte = enable_reg[7:0];
         pulse_pattern_pkg::IDX_OUT_HI:  rd_byte = value_all[15:8];
         pulse_pattern_pkg::IDX_OUT_LO:  rd_byte = value_all[7:0];
         pulse_pattern_pkg::IDX_NEXT_UP: rd_byte = same_up ? next_reg[15:8]
                                                   : {next_reg[15:12], pulse_pattern_pkg::FILL_NIB};
         pulse_pattern_pkg::IDX_NEXT_LO: rd_byte = same_lo ? next_reg[7:0]
                                                   : {next_reg[7:4], pulse_pattern_pkg::FILL_NIB};
         pulse_pattern_pkg::IDX_NEXT_G2: rd_byte = same_up ? pulse_pattern_pkg::FILL_BYTE
                                                   : {pulse_pattern_pkg::FILL_NIB, next_reg[11:8]};
         pulse_pattern_pkg::IDX_NEXT_G0: rd_byte = same_lo ? pulse_pattern_pkg::FILL_BYTE
                                                   : {pulse_pattern_pkg::FILL_NIB, next_reg[3:0]};
         default:                        rd_byte = 8'h00;
      endcase
   end

   // register writes
   always_comb begin
      trig_next   = trig_reg;
      pol_next    = pol_reg;
      enable_next = enable_reg;
      next_next   = next_reg;
      grp_wr      = 4'h0;
      if (wr_fire && wr_lane) begin
         case (wr_idx)
            pulse_pattern_pkg::IDX_TRIG:    trig_next = wr_byte;
            pulse_pattern_pkg::IDX_POL:     pol_next = wr_byte[3:0];
            pulse_pattern_pkg::IDX_EN_HI:   enable_next[15:8] = wr_byte;
            pulse_pattern_pkg::IDX_EN_LO:   enable_next[7:0] = wr_byte;
            pulse_pattern_pkg::IDX_OUT_HI:  grp_wr = 4'hC;
            pulse_pattern_pkg::IDX_OUT_LO:  grp_wr = 4'h3;
            pulse_pattern_pkg::IDX_NEXT_UP: begin
               next_next[15:12] = wr_byte[7:4];
               if (same_up) begin
                  next_next[11:8] = wr_byte[3:0];
               end
            end
            pulse_pattern_pkg::IDX_NEXT_LO: begin
               next_next[7:4] = wr_byte[7:4];
               if (same_lo) begin
                  next_next[3:0] = wr_byte[3:0];
               end
            end
            pulse_pattern_pkg::IDX_NEXT_G2: begin
               if (!same_up) begin
                  next_next[11:8] = wr_byte[3:0];
               end
            end
            pulse_pattern_pkg::IDX_NEXT_G0: begin
               if (!same_lo) begin
                  next_next[3:0] = wr_byte[3:0];
               end
            end
            default: begin
               trig_next = trig_reg;
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         trig_reg   <= pulse_pattern_pkg::RST_TRIG;
         pol_reg    <= pulse_pattern_pkg::RST_POL;
         enable_reg <= pulse_pattern_pkg::RST_EN;
         next_reg   <= pulse_pattern_pkg::RST_NEXT;
         oe_reg     <= pulse_pattern_pkg::RST_EN;
      end else begin
         trig_reg   <= trig_next;
         pol_reg    <= pol_next;
         enable_reg <= enable_next;
         next_reg   <= next_next;
         oe_reg     <= enable_next;
      end
   end

   // four output groups
   for (genvar g = 0; g < pulse_pattern_pkg::GROUPS; g++) begin : grp
      pattern_group #(
         .W (pulse_pattern_pkg::GROUP_W)
      ) u_group (
         .mclk       (mclk),
         .reset      (reset),
         .sw_write   (grp_wr[g]),
         .sw_data    (wr_byte[4*(g%2)+:4]),
         .pin_enable (enable_next[4*g+:4]),
         .trig_sel   (trig_reg[pulse_pattern_pkg::TRIG_W*g+:pulse_pattern_pkg::TRIG_W]),
         .direct     (pol_next[g]),
         .next_bits  (next_reg[4*g+:4]),
         .cmp_match  (timer_unit_match),
         .value_reg  (value_all[4*g+:4]),
         .pin_reg    (pin_all[4*g+:4])
      );
   end

   assign pattern_pin    = pin_all;
   assign pattern_pin_oe = oe_reg;

   property p_pin_route;
      @(posedge mclk) disable iff (reset)
         !reset |=> pattern_pin_oe == enable_reg;
   endproperty
   a_pin_route: assert property (p_pin_route) else $error("pin routing mismatch");

   property p_alias_ones_up;
      @(posedge mclk) disable iff (reset)
         ar_take && rd_idx == pulse_pattern_pkg::IDX_NEXT_G2 && same_up
         |=> rvalid && rdata[7:0] == 8'hFF;
   endproperty
   a_alias_ones_up: assert property (p_alias_ones_up) else $error("alias not all ones");

   property p_split_up;
      @(posedge mclk) disable iff (reset)
         wr_fire && wr_idx == pulse_pattern_pkg::IDX_NEXT_UP && !same_up
         |=> next_reg[11:8] == $past(next_reg[11:8]);
   endproperty
   a_split_up: assert property (p_split_up) else $error("group 2 bits written");

   property p_split_g2;
      @(posedge mclk) disable iff (reset)
         wr_fire && wr_lane && wr_idx == pulse_pattern_pkg::IDX_NEXT_G2 && !same_up
         |=> next_reg[11:8] == $past(wr_byte[3:0]) && next_reg[15:12] == $past(next_reg[15:12]);
   endproperty
   a_split_g2: assert property (p_split_g2) else $error("group 2 write wrong");

   property p_alias_locked_lo;
      @(posedge mclk) disable iff (reset)
         wr_fire && wr_idx == pulse_pattern_pkg::IDX_NEXT_G0 && same_lo
         |=> next_reg == $past(next_reg);
   endproperty
   a_alias_locked_lo: assert property (p_alias_locked_lo) else $error("alias accepted write");
endmodule
`default_nettype wire

// file: bench/pin_timer_model.sv
`timescale 1ns/1ps
`default_nettype none
module pin_timer_model (
   // clock
   input  wire logic      mclk,
   // compare matches toward the pattern unit
   output var  logic [3:0] timer_unit_match
);
   initial timer_unit_match = 4'h0;

   // one-cycle match on a channel, after an optional idle gap
   task automatic pulse(input int ch, input int gap);
      repeat (gap) @(posedge mclk);
      @(posedge mclk);
      timer_unit_match <= 4'(1 << ch);
      @(posedge mclk);
      timer_unit_match <= 4'h0;
   endtask
endmodule
`default_nettype wire

// file: bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_count++; \
   $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module testbench;
   logic                                  mclk    = 1'b0;
   logic                                  reset   = 1'b1;
   logic [pulse_pattern_pkg::ADDR_W-1:0]  awaddr  = '0;
   logic [pulse_pattern_pkg::ADDR_W-1:0]  araddr  = '0;
   logic [31:0]                           wdata   = 32'h0;
   logic                                  awvalid = 1'b0;
   logic                                  wvalid  = 1'b0;
   logic                                  bready  = 1'b0;
   logic                                  arvalid = 1'b0;
   logic                                  rready  = 1'b0;
   logic                                  awready, wready, bvalid, arready, rvalid;
   logic [1:0]                            bresp, rresp;
   logic [31:0]                           rdata;
   logic [3:0]                            match;
   logic [15:0]                           pins, oe;
   int                                    err_count   = 0;
   int                                    checks_done = 0;

   always #20 mclk = ~mclk;

   pulse_pattern_output_regs u_pulse_pattern_output_regs (
      .mclk(mclk), .reset(reset),
      .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(4'h1), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .timer_unit_match(match), .pattern_pin(pins), .pattern_pin_oe(oe)
   );

   pin_timer_model u_pin_timer_model (
      .mclk(mclk),
      .timer_unit_match(match)
   );

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // one write on the register bus
   task automatic wr(input logic [15:0] i, input logic [7:0] d, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge mclk);
      awaddr  <= {i, 2'h0};
      wdata   <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && n < 40);
      bready <= 1'b0;
      `CHK(bresp, er)
      if (n >= 40) begin
         $display("[FAIL] %0t write answer timeout", $time);
         err_count++;
         report_and_stop();
      end
   endtask

   // one read on the register bus
   task automatic rd(input logic [15:0] i, output logic [7:0] d, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge mclk);
      araddr  <= {i, 2'h0};
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && n < 40);
      rready <= 1'b0;
      d = rdata[7:0];
      `CHK(rresp, er)
      if (n >= 40) begin
         $display("[FAIL] %0t read answer timeout", $time);
         err_count++;
         report_and_stop();
      end
   endtask

   task automatic rc(input logic [15:0] i, input logic [7:0] e);
      logic [7:0] v;
      rd(i, v, pulse_pattern_pkg::RESP_OKAY);
      `CHK(v, e)
   endtask

   task automatic t_reset();
      `CHK(oe, 16'h0000)
      `CHK(pins, 16'h0000)
      rc(pulse_pattern_pkg::IDX_OUT_HI, 8'h00);
      rc(pulse_pattern_pkg::IDX_OUT_LO, 8'h00);
      rc(pulse_pattern_pkg::IDX_NEXT_UP, 8'h00);
      rc(pulse_pattern_pkg::IDX_NEXT_G2, 8'hFF);
      rc(pulse_pattern_pkg::IDX_NEXT_LO, 8'h00);
      rc(pulse_pattern_pkg::IDX_NEXT_G0, 8'hFF);
      $display("reset test done");
   endtask

   task automatic t_modes();
      wr(pulse_pattern_pkg::IDX_NEXT_UP, 8'hA5, pulse_pattern_pkg::RESP_OKAY);
      wr(pulse_pattern_pkg::IDX_NEXT_G2, 8'h12, pulse_pattern_pkg::RESP_OKAY);
      rc(pulse_pattern_pkg::IDX_NEXT_UP, 8'hA5);
      rc(pulse_pattern_pkg::IDX_NEXT_G2, 8'hFF);
      wr(pulse_pattern_pkg::IDX_NEXT_LO, 8'h3C, pulse_pattern_pkg::RESP_OKAY);
      wr(pulse_pattern_pkg::IDX_NEXT_G0, 8'h12, pulse_pattern_pkg::RESP_OKAY);
      rc(pulse_pattern_pkg::IDX_NEXT_LO, 8'h3C);
      rc(pulse_pattern_pkg::IDX_NEXT_G0, 8'hFF);
      // group triggers 3:1 2:0 1:3 0:2, all four codes in use
      wr(pulse_pattern_pkg::IDX_TRIG, 8'h4E, pulse_pattern_pkg::RESP_OKAY);
      wr(pulse_pattern_pkg::IDX_NEXT_UP, 8'h3C, pulse_pattern_pkg::RESP_OKAY);
      wr(pulse_pattern_pkg::IDX_NEXT_G2, 8'h96, pulse_pattern_pkg::RESP_OKAY);
      rc(pulse_pattern_pkg::IDX_NEXT_UP, 8'h3F);
      rc(pulse_pattern_pkg::IDX_NEXT_G2, 8'hF6);
      wr(pulse_pattern_pkg::IDX_NEXT_LO, 8'hC3, pulse_pattern_pkg::RESP_OKAY);
      wr(pulse_pattern_pkg::IDX_NEXT_G0, 8'h5A, pulse_pattern_pkg::RESP_OKAY);
      rc(pulse_pattern_pkg::IDX_NEXT_LO, 8'hCF);
      rc(pulse_pattern_pkg::IDX_NEXT_G0, 8'hFA);
      $display("next data layout test done");
   endtask

   task automatic t_lock();
      wr(pulse_pattern_pkg::IDX_OUT_LO, 8'hFF, pulse_pattern_pkg::RESP_OKAY);
      rc(pulse_pattern_pkg::IDX_OUT_LO, 8'hFF);
      wr(pulse_pattern_pkg::IDX_EN_LO, 8'h0F, pulse_pattern_pkg::RESP_OKAY);
      `CHK(oe, 16'h000F)
      `CHK(pins, 16'h000F)
      wr(pulse_pattern_pkg::IDX_OUT_LO, 8'h00, pulse_pattern_pkg::RESP_OKAY);
      rc(pulse_pattern_pkg::IDX_OUT_LO, 8'h0F);
      `CHK(pins, 16'h000F)
      $display("write lock test done");
   endtask

   task automatic t_match();
      int          grp [4] = '{2, 3, 0, 1};
      logic [3:0]  nd [4]  = '{4'hA, 4'hC, 4'h6, 4'h3};
      logic [15:0] exp;
      logic [7:0]  hi, lo;
      exp = 16'h000F;
      wr(pulse_pattern_pkg::IDX_EN_HI, 8'hFF, pulse_pattern_pkg::RESP_OKAY);
      wr(pulse_pattern_pkg::IDX_EN_LO, 8'hFF, pulse_pattern_pkg::RESP_OKAY);
      for (int ch = 0; ch < 4; ch++) begin
         u_pin_timer_model.pulse(ch, ch);
         exp[4*grp[ch] +: 4] = nd[grp[ch]];
         rd(pulse_pattern_pkg::IDX_OUT_HI, hi, pulse_pattern_pkg::RESP_OKAY);
         rd(pulse_pattern_pkg::IDX_OUT_LO, lo, pulse_pattern_pkg::RESP_OKAY);
         `CHK({hi, lo}, exp)
         `CHK(pins, exp)
      end
      wr(pulse_pattern_pkg::IDX_EN_HI, 8'h0F, pulse_pattern_pkg::RESP_OKAY);
      wr(pulse_pattern_pkg::IDX_NEXT_UP, 8'h90, pulse_pattern_pkg::RESP_OKAY);
      u_pin_timer_model.pulse(1, 0);
      rc(pulse_pattern_pkg::IDX_OUT_HI, 8'h36);
      `CHK(oe, 16'h0FFF)
      `CHK(pins, 16'h06CA)
      wr(pulse_pattern_pkg::IDX_POL, 8'h0A, pulse_pattern_pkg::RESP_OKAY);
      `CHK(pins, 16'h09C5)
      wr(16'hFF50, 8'h00, pulse_pattern_pkg::RESP_DECERR);
      rd(16'hFF50, lo, pulse_pattern_pkg::RESP_DECERR);
      `CHK(lo, 8'h00)
      $display("match and polarity test done");
   endtask

   initial begin
      repeat (20000) @(posedge mclk);
      $display("[FAIL] %0t run timeout", $time);
      err_count++;
      report_and_stop();
   end

   initial begin
      repeat (2) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      t_reset();
      t_modes();
      t_lock();
      t_match();
      report_and_stop();
   end
endmodule
`default_nettype wire
